// ### logic/rcc_top.sv
// Configuration register for the radio control state machine: auto-calibration and ready timeout.
// Assumes accesses arrive already decoded from the serial port, synchronous to the core clock.
//
// Summary of operation
// - Autocal 0 never, 1 on leaving idle, 2 on returning to idle.
// - Autocal 3 calibrates only on every fourth return to idle.
// - Ready-low stays high until ripple expirations reach 1, 16, 64 or 256.
// - Power-up timeout field survives sleep; other fields return to defaults.
`timescale 1ns/1ps
module rcc_top
    import rcc_pkg::*;
#(
    parameter int RIPPLE_W = RCC_RIPPLE_W
)
(
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    input  wire logic       cfg_wr_en_in,
    input  wire logic       cfg_rd_en_in,
    input  wire logic [5:0] cfg_addr_in,
    input  wire logic [7:0] cfg_wdata_in,
    output logic      [7:0] cfg_rdata_out,
    input  wire logic       leave_idle_in,
    input  wire logic       return_idle_in,
    input  wire logic       calibrate_strobe_in,
    input  wire logic       sleep_in,
    input  wire logic       xosc_on_in,
    output logic            cal_start_out,
    output logic            chip_ready_low_out
);

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic logic [8:0] expire_target(input logic [1:0] sel);
        case (sel)
            2'b00:   expire_target = RCC_EXPIRE_SEL0;
            2'b01:   expire_target = RCC_EXPIRE_SEL1;
            2'b10:   expire_target = RCC_EXPIRE_SEL2;
            default: expire_target = RCC_EXPIRE_SEL3;
        endcase
    endfunction : expire_target

    // Ripple width needs room for a wrap; very wide counters stretch the wait past reason
    generate
        if (RIPPLE_W < 2 || RIPPLE_W > 16)
        begin : g_bad_ripple
            $error("ripple counter width out of range");
        end
    endgenerate

    rcc_cfg_t                  cfg_r;
    rcc_cfg_t                  cfg_nxt;
    logic [1:0]                ret_cnt_r;
    logic [1:0]                ret_cnt_nxt;
    logic [RIPPLE_W-1:0]       ripple_r;
    logic [RIPPLE_W-1:0]       ripple_nxt;
    logic [RCC_EXPIRE_W-1:0]   expire_r;
    logic [RCC_EXPIRE_W-1:0]   expire_nxt;
    logic [7:0]                rdata_nxt;
    logic                      cal_nxt;
    logic                      ready_low_nxt;

    wire logic                 hit_w     = cfg_addr_in == RCC_CFG_OFFSET;
    wire logic                 wr_w      = cfg_wr_en_in && hit_w;
    wire logic [8:0]           target_w  = expire_target(cfg_r.powerup_ready_timeout);
    wire logic                 ripple_ex = &ripple_r;
    wire logic                 mode3_ret = (cfg_r.synth_autocal_select == RCC_CAL_RETURN_4) && return_idle_in;
    wire logic                 fourth_w  = ret_cnt_r == RCC_EVERY_NTH_LAST;
    wire logic                 reached_w = expire_r == target_w;

    // Register write; sleep drops everything except the timeout field
    always_comb
    begin
        cfg_nxt = cfg_r;
        if (wr_w)
        begin
            cfg_nxt.synth_autocal_select  = rcc_autocal_t'(cfg_wdata_in[RCC_AUTOCAL_LSB +: 2]);
            cfg_nxt.powerup_ready_timeout = cfg_wdata_in[RCC_TIMEOUT_LSB +: 2];
        end
        if (sleep_in)
        begin
            cfg_nxt.synth_autocal_select  = rcc_autocal_t'(RCC_AUTOCAL_RESET);
            cfg_nxt.powerup_ready_timeout = cfg_r.powerup_ready_timeout;
        end
    end

    // Reserved positions are hard zeros, so nothing stored can leak out
    assign rdata_nxt = (cfg_rd_en_in && hit_w) ?
                       {2'b00, cfg_r.synth_autocal_select, cfg_r.powerup_ready_timeout, 2'b00} : 8'h00;

    // Calibration requests by mode
    assign cal_nxt = calibrate_strobe_in
                   || ((cfg_r.synth_autocal_select == RCC_CAL_LEAVE)  && leave_idle_in)
                   || ((cfg_r.synth_autocal_select == RCC_CAL_RETURN) && return_idle_in)
                   || (mode3_ret && fourth_w);

    // Return counter only runs in every-fourth mode; cleared otherwise so a mode change restarts it
    assign ret_cnt_nxt = (cfg_r.synth_autocal_select != RCC_CAL_RETURN_4) ? 2'b00 :
                         mode3_ret ? ret_cnt_r + 2'b01 : ret_cnt_r;

    // Ripple counter runs only while the crystal runs, so every start begins a full wrap
    assign ripple_nxt    = xosc_on_in ? ripple_r + RIPPLE_W'(1) : '0;

    // Expiration count saturates at the target; a smaller target later still reads as reached
    assign expire_nxt    = !xosc_on_in ? '0 :
                           (ripple_ex && (expire_r < target_w)) ? expire_r + 9'h001 : expire_r;
    assign ready_low_nxt = !(xosc_on_in && (expire_r >= target_w));

    // ************************************************************
    // State
    // ************************************************************
    // All state and every output register; reset values are constants only
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_r              <= '{rcc_autocal_t'(RCC_AUTOCAL_RESET), RCC_TIMEOUT_RESET};
            ret_cnt_r          <= 2'b00;
            ripple_r           <= '0;
            expire_r           <= '0;
            cfg_rdata_out      <= 8'h00;
            cal_start_out      <= 1'b0;
            chip_ready_low_out <= 1'b1;
        end
        else
        begin
            cfg_r              <= cfg_nxt;
            ret_cnt_r          <= ret_cnt_nxt;
            ripple_r           <= ripple_nxt;
            expire_r           <= expire_nxt;
            cfg_rdata_out      <= rdata_nxt;
            cal_start_out      <= cal_nxt;
            chip_ready_low_out <= ready_low_nxt;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_leave_m1;
        cfg_r.synth_autocal_select == RCC_CAL_LEAVE && leave_idle_in;
    endsequence
    sequence s_ret_m2;
        cfg_r.synth_autocal_select == RCC_CAL_RETURN && return_idle_in;
    endsequence

    property p_cal_mode1;
        @(posedge core_clk_in) disable iff (rst_in) s_leave_m1 |=> cal_start_out;
    endproperty
    a_cal_mode1: assert property (p_cal_mode1) else $error("leave idle did not calibrate");

    property p_cal_mode2;
        @(posedge core_clk_in) disable iff (rst_in) s_ret_m2 |=> cal_start_out;
    endproperty
    a_cal_mode2: assert property (p_cal_mode2) else $error("return idle did not calibrate");

    property p_cal_never;
        @(posedge core_clk_in) disable iff (rst_in)
            cfg_r.synth_autocal_select == RCC_CAL_NEVER && !calibrate_strobe_in |=> !cal_start_out;
    endproperty
    a_cal_never: assert property (p_cal_never) else $error("calibration without strobe in mode 0");

    property p_cal_fourth;
        @(posedge core_clk_in) disable iff (rst_in)
            mode3_ret && !calibrate_strobe_in |=> cal_start_out == $past(fourth_w);
    endproperty
    a_cal_fourth: assert property (p_cal_fourth) else $error("every fourth calibration wrong");

    property p_ready_cause;
        @(posedge core_clk_in) disable iff (rst_in)
            !chip_ready_low_out |-> $past(xosc_on_in) && ($past(expire_r) >= $past(target_w));
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready before timeout expired");

    property p_ready_fast;
        @(posedge core_clk_in) disable iff (rst_in)
            xosc_on_in && reached_w |=> !chip_ready_low_out;
    endproperty
    a_ready_fast: assert property (p_ready_fast) else $error("ready not given at timeout");

    property p_sleep_keep;
        @(posedge core_clk_in) disable iff (rst_in)
            sleep_in |=> cfg_r.powerup_ready_timeout == $past(cfg_r.powerup_ready_timeout);
    endproperty
    a_sleep_keep: assert property (p_sleep_keep) else $error("timeout field lost in sleep");

    property p_reserved;
        @(posedge core_clk_in) disable iff (rst_in) cfg_rdata_out[7:6] == 2'b00 && cfg_rdata_out[1:0] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    // Manual strobe works in every mode, so software always has a way out
    property p_cal_strobe;
        @(posedge core_clk_in) disable iff (rst_in)
            calibrate_strobe_in |=> cal_start_out;
    endproperty
    a_cal_strobe: assert property (p_cal_strobe) else $error("strobe did not calibrate");

    // Partial return counts must not survive a mode change
    property p_ret_clear;
        @(posedge core_clk_in) disable iff (rst_in)
            cfg_r.synth_autocal_select != RCC_CAL_RETURN_4 |=> ret_cnt_r == 2'b00;
    endproperty
    a_ret_clear: assert property (p_ret_clear) else $error("return count kept outside mode 3");

    // Losing the crystal withdraws ready at once
    property p_ready_off;
        @(posedge core_clk_in) disable iff (rst_in)
            !xosc_on_in |=> chip_ready_low_out;
    endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready held without crystal");

    // Sleep drops the calibration choice back to never
    property p_sleep_autocal;
        @(posedge core_clk_in) disable iff (rst_in)
            sleep_in |=> cfg_r.synth_autocal_select == RCC_CAL_NEVER;
    endproperty
    a_sleep_autocal: assert property (p_sleep_autocal) else $error("autocal kept over sleep");

    // Read data bus is quiet outside a mapped read
    property p_idle_read;
        @(posedge core_clk_in) disable iff (rst_in)
            !(cfg_rd_en_in && hit_w) |=> cfg_rdata_out == 8'h00;
    endproperty
    a_idle_read: assert property (p_idle_read) else $error("read data outside a mapped read");

endmodule : rcc_top

// ### logic/rcc_pkg.sv
// Constants and types for the radio calibration and power-up configuration block.
// Assumes a single core clock and an upstream serial port decoder that issues register accesses.
package rcc_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [5:0] RCC_CFG_OFFSET      = 6'h18;
    localparam int         RCC_AUTOCAL_LSB     = 4;
    localparam int         RCC_TIMEOUT_LSB     = 2;
    localparam logic [1:0] RCC_AUTOCAL_RESET   = 2'h0;
    localparam logic [1:0] RCC_TIMEOUT_RESET   = 2'h1;

    // ************************************************************
    // Counters
    // ************************************************************
    localparam int         RCC_RIPPLE_W        = 6;
    localparam int         RCC_EXPIRE_W        = 9;
    localparam logic [1:0] RCC_EVERY_NTH_LAST  = 2'h3;
    localparam logic [8:0] RCC_EXPIRE_SEL0     = 9'h001;
    localparam logic [8:0] RCC_EXPIRE_SEL1     = 9'h010;
    localparam logic [8:0] RCC_EXPIRE_SEL2     = 9'h040;
    localparam logic [8:0] RCC_EXPIRE_SEL3     = 9'h100;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        RCC_CAL_NEVER     = 2'b00,
        RCC_CAL_LEAVE     = 2'b01,
        RCC_CAL_RETURN    = 2'b10,
        RCC_CAL_RETURN_4  = 2'b11
    } rcc_autocal_t;

    typedef struct packed {
        rcc_autocal_t synth_autocal_select;
        logic [1:0]   powerup_ready_timeout;
    } rcc_cfg_t;

endpackage : rcc_pkg

// ### dv/rcc_host_model.sv
// Host model: drives the decoded configuration port one access at a time.
// Assumes the bench calls its task; port inputs change only at falling edges.
`timescale 1ns/1ps
module rcc_host_model
    import rcc_pkg::*;
(
    input  wire logic       clk_in,
    output logic            wr_en_out,
    output logic            rd_en_out,
    output logic [5:0]      addr_out,
    output logic [7:0]      wdata_out,
    input  wire logic [7:0] rdata_in
);
    // Fast wake-up choice, used for the one-expiration case of the ready-delay test
    localparam logic [1:0] PREFERRED_TIMEOUT = 2'h0;

    // Idle port at time zero
    initial
    begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out  = 6'h00;
        wdata_out = 8'h00;
    end

    // Strobe held over one sampling edge; read data taken in the next cycle
    task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    begin
        @(negedge clk_in);
        wr_en_out = wr;
        rd_en_out = ~wr;
        addr_out  = a;
        wdata_out = d;
        @(negedge clk_in);
        q         = rdata_in;
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out  = ~a; // Released lines show a changed value, not the last one
        wdata_out = ~d;
    end
    endtask : access
endmodule : rcc_host_model

// ### dv/test_radio_calibration_and_powerup_config.sv
// Testbench: table of calibration events, then reset, reserved, sleep and ready-timeout cases.
// Assumes the host model drives the register port; events change at falling edges.
`timescale 1ns/1ps
module test_radio_calibration_and_powerup_config;
    import rcc_pkg::*;
    typedef struct packed { logic [7:0] wd; logic [2:0] ev; logic cal; } rcc_row_t;
    logic       clk = 1'b0, rst = 1'b1, sleep = 1'b0, xosc = 1'b0, wr, rd, cal, rdy_n;
    logic [2:0] ev = 3'b000; // {strobe, return, leave}
    logic [5:0] addr;
    logic [7:0] wdata, rdata, q;
    int         n_mismatch = 0, compares = 0, cycles = 0;
    // Mode row, event, expected calibration pulse
    rcc_row_t   rows [9] = '{'{8'h00,3'b001,1'b0}, '{8'h00,3'b010,1'b0}, '{8'h00,3'b100,1'b1},
                             '{8'h10,3'b001,1'b1}, '{8'h10,3'b010,1'b0}, '{8'h20,3'b001,1'b0},
                             '{8'h20,3'b010,1'b1}, '{8'h30,3'b001,1'b0}, '{8'h30,3'b100,1'b1}};

    always #2 clk = ~clk;
    rcc_top dut (.core_clk_in(clk), .rst_in(rst), .cfg_wr_en_in(wr), .cfg_rd_en_in(rd), .cfg_addr_in(addr),
        .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .leave_idle_in(ev[0]), .return_idle_in(ev[1]),
        .calibrate_strobe_in(ev[2]), .sleep_in(sleep), .xosc_on_in(xosc), .cal_start_out(cal),
        .chip_ready_low_out(rdy_n));
    rcc_host_model host (.clk_in(clk), .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr), .wdata_out(wdata),
        .rdata_in(rdata));

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    begin
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask : check

    // One-cycle event pulse; the calibration answer stands in the following cycle
    task automatic pulse(input logic [2:0] e, input logic exp);
    begin
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = 3'b000;
        check("cal_start", {7'h00, cal}, {7'h00, exp});
    end
    endtask : pulse

    task automatic conclude();
    begin
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : conclude

    // Hang guard well above the longest ready wait
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    initial
    begin
        repeat (10) @(negedge clk);
        check("reset_ready", {7'h00, rdy_n}, 8'h01);
        check("reset_cal", {7'h00, cal}, 8'h00);
        rst = 1'b0;
        host.access(1'b0, 6'h18, 8'h00, q);
        check("reset_value", q, 8'h04);
        foreach (rows[i])
        begin
            host.access(1'b1, 6'h18, rows[i].wd, q);
            pulse(rows[i].ev, rows[i].cal);
        end
        // Only every fourth return to idle calibrates
        for (int k = 0; k < 8; k++)
            pulse(3'b010, k % 4 == 3);
        // Leaving every-fourth mode forgets partial counts
        pulse(3'b010, 1'b0);
        pulse(3'b010, 1'b0);
        host.access(1'b1, 6'h18, 8'h20, q);
        host.access(1'b1, 6'h18, 8'h30, q);
        for (int k = 0; k < 4; k++)
            pulse(3'b010, k == 3);
        host.access(1'b1, 6'h18, 8'hFF, q);
        host.access(1'b0, 6'h18, 8'h00, q);
        check("reserved", q, 8'h3C);
        @(negedge clk);
        sleep = 1'b1;
        @(negedge clk);
        sleep = 1'b0;
        host.access(1'b0, 6'h18, 8'h00, q);
        check("after_sleep", q, 8'h0C);
        host.access(1'b1, 6'h19, 8'h00, q);
        host.access(1'b0, 6'h19, 8'h00, q);
        check("unmapped", q, 8'h00);
        host.access(1'b0, 6'h18, 8'h00, q);
        check("kept", q, 8'h0C);
        // Ready delay for one and sixteen ripple expirations
        for (int k = 0; k < 2; k++)
        begin
            host.access(1'b1, 6'h18, {4'h0, k ? 2'h1 : host.PREFERRED_TIMEOUT, 2'h0}, q);
            xosc = 1'b1;
            repeat (k ? 1024 : 64) @(negedge clk);
            check("ready_early", {7'h00, rdy_n}, 8'h01);
            repeat (3) @(negedge clk);
            check("ready", {7'h00, rdy_n}, 8'h00);
            xosc = 1'b0;
            repeat (2) @(negedge clk);
            check("ready_off", {7'h00, rdy_n}, 8'h01);
        end
        // Mid-run reset while ready: ready withdrawn, timeout back to sixteen expirations
        host.access(1'b1, 6'h18, 8'h30, q);
        xosc = 1'b1;
        repeat (70) @(negedge clk);
        check("ready_before_reset", {7'h00, rdy_n}, 8'h00);
        rst = 1'b1;
        @(negedge clk);
        check("ready_in_reset", {7'h00, rdy_n}, 8'h01);
        rst = 1'b0;
        repeat (70) @(negedge clk);
        check("ready_after_reset", {7'h00, rdy_n}, 8'h01);
        xosc = 1'b0;
        host.access(1'b0, 6'h18, 8'h00, q);
        check("second_reset", q, 8'h04);
        conclude();
    end
endmodule : test_radio_calibration_and_powerup_config
